// File: hw/seq_step_cfg.svh
// Purpose: Offsets, field positions, reset values and timing for the step-action block.
// Assumes: 32-bit APB data, byte addresses on paddr[7:0].
// Notes: Definitions only.
`ifndef SEQ_STEP_CFG_SVH
`define SEQ_STEP_CFG_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFF_CTRL 8'h00
`define OFF_REG_STEP 8'h04
`define OFF_REG_MODE 8'h08
`define OFF_PIN_RISE 8'h0C
`define OFF_PIN_FALL 8'h10
`define OFF_PIN_POL 8'h14
`define OFF_WAIT_TIME 8'h18
`define OFF_STATUS 8'h1C
`define OFF_OUTS 8'h20
// ----------------------------------------
// Fields
// ----------------------------------------
`define CTRL_DEF_SUP 0
`define CTRL_WAIT_MODE 1
`define CTRL_TO_EN 2
`define CTRL_FIRST_EN 3
`define CTRL_WSTEP_LSB 4
`define CTRL_GSTEP_LSB 8
`define CTRL_MAX_LSB 12
`define CTRL_GSEL_LSB 16
`define MODE_CONF_LSB 8
`define ST_WAITING 0
`define ST_FAULT 1
`define ST_EVENT 2
`define OUTS_SEL_LSB 8
`define OUTS_PIN_LSB 16
`define OUTS_GRP_LSB 24
`define CTRL_RST 32'h0000_F000
`define STEP_W 4
`define GRP_W 8
// ----------------------------------------
// Timing
// ----------------------------------------
`define PCLK_KHZ 10000
`define WAIT_TIMEOUT_MS 500
`define WAIT_TIMEOUT_CYCLES (`WAIT_TIMEOUT_MS * `PCLK_KHZ)
`endif

// File: hw/seq_step_pkg.sv
// Purpose: Types shared by the step-action block and its bench.
// Assumes: Sixteen sequencer steps.
// Notes: Constants live in seq_step_cfg.svh.
package seq_step_pkg;
    typedef struct packed {
        logic valid;
        logic up;
        logic [3:0] index;
    } step_cmd_t;
    typedef enum logic [1:0] {WAIT_IDLE, WAIT_EVENT, WAIT_DELAY} wait_state_t;
endpackage

// File: hw/sequencer_step_actions.sv
// Purpose: Step actions of the power sequencer: regulators, pins, wait step, group gate.
// Assumes: step_cmd pulses once per step reached; reset_mode and enter_low_power
//          come from logic on pclk.
// Notes: Registers on APB, zero wait states.
// What this block does
// - Regulator on counting up if auto or config set, off counting down if config clear
// - Many regulators may share one step
// - Up: enable if auto or config, select A
// - Down, config clear: disable, select A
// - Down, config set: stay on, select B
// - Default supplies on step 0 enable on low power
// - Step 0 otherwise acts like other steps
// - Default supply clear: step 0 does nothing
// - First linear regulator kept on in reset mode if CTRL_FIRST_EN, default supply and its config are set
// - Each pin has rise and fall steps
// - Pins inactive during reset mode
// - Pin actions only at steps above zero
// - Rise step: active up, inactive down
// - Fall step: inactive up, active down
// - Wait step holds until trigger event
// - Wait timeout: shutdown request, fault flag set
// - Wait step may be a programmed delay
// - Up past gate step enables group
// - Down below gate step disables group
// - Sixteen steps, evaluated in current direction
// - Pointer above maximum count is ignored
// - Power-down reuses pointers in reverse
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
`include "seq_step_cfg.svh"
module sequencer_step_actions #(
    parameter int NUM_REG = 7,
    parameter int FIRST_LIN = 3,
    parameter int NUM_PIN = 5,
    parameter int TIMEOUT_CYCLES = `WAIT_TIMEOUT_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sequencer side
    input wire seq_step_pkg::step_cmd_t step_cmd,
    input wire logic reset_mode,
    input wire logic enter_low_power,
    output logic wait_hold,
    output logic shutdown_req,
    // Wait trigger pin
    input wire logic wait_trigger_input,
    // Controlled outputs
    output logic [NUM_REG-1:0] reg_enable,
    output logic [NUM_REG-1:0] reg_select_b,
    output logic [NUM_PIN-1:0] pin_level,
    output logic [`GRP_W-1:0] group_enable
);
    if (NUM_REG > 8 || NUM_REG < 1 || FIRST_LIN >= NUM_REG || NUM_PIN > 8 || NUM_PIN < 1
        || TIMEOUT_CYCLES < 2) begin : g_bad
        $error("sequencer_step_actions: unsupported parameters");
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [31:0] ctrl_ff, reg_step_ff, reg_mode_ff, rise_ff, fall_ff, pol_ff, wait_time_ff;
    logic fault_ff, event_ff, shutdown_ff;
    logic [NUM_REG-1:0] en_ff, sel_ff;
    logic [NUM_PIN-1:0] act_ff;
    logic [`GRP_W-1:0] grp_ff;
    logic [31:0] cnt_ff;
    seq_step_pkg::wait_state_t wst_ff;
    logic sync1_ff, sync2_ff, sync3_ff;
    logic [31:0] rd_ff;

    wire logic wr = psel && penable && pwrite;
    wire logic def_sup = ctrl_ff[`CTRL_DEF_SUP];
    wire logic [3:0] max_cnt = ctrl_ff[`CTRL_MAX_LSB +: `STEP_W];
    wire logic [3:0] wait_step = ctrl_ff[`CTRL_WSTEP_LSB +: `STEP_W];
    wire logic [3:0] gate_step = ctrl_ff[`CTRL_GSTEP_LSB +: `STEP_W];
    wire logic [`GRP_W-1:0] gate_sel = ctrl_ff[`CTRL_GSEL_LSB +: `GRP_W];
    wire logic keep_first = def_sup && ctrl_ff[`CTRL_FIRST_EN]
        && reg_mode_ff[`MODE_CONF_LSB + FIRST_LIN];

    function automatic logic [3:0] ptr(input logic [31:0] w, input int i);
        ptr = w[i*`STEP_W +: `STEP_W];
    endfunction

    // Step zero is taken only when allowed; anything above the maximum is left alone.
    // The command and maximum are arguments so that continuous users follow their changes.
    function automatic logic hit(input seq_step_pkg::step_cmd_t c, input logic [3:0] mx,
            input logic [3:0] p, input logic allow0);
        hit = c.valid && p == c.index && p <= mx
            && (p != 4'h0 || allow0);
    endfunction

    function automatic logic known(input logic [7:0] a);
        known = a <= `OFF_OUTS && a[1:0] == 2'h0;
    endfunction

    // ----------------------------------------
    // APB
    // ----------------------------------------
    assign pready = 1'b1;
    assign pslverr = psel && penable && !known(paddr);
    assign prdata = rd_ff;

    // Read data is captured in the setup cycle so the access phase needs no wait.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ff <= 32'h0000_0000;
        end else if (psel && !penable) begin
            case (paddr)
                `OFF_CTRL: rd_ff <= ctrl_ff;
                `OFF_REG_STEP: rd_ff <= reg_step_ff;
                `OFF_REG_MODE: rd_ff <= reg_mode_ff;
                `OFF_PIN_RISE: rd_ff <= rise_ff;
                `OFF_PIN_FALL: rd_ff <= fall_ff;
                `OFF_PIN_POL: rd_ff <= pol_ff;
                `OFF_WAIT_TIME: rd_ff <= wait_time_ff;
                `OFF_STATUS: begin
                    rd_ff <= 32'h0000_0000;
                    rd_ff[`ST_WAITING] <= wst_ff != seq_step_pkg::WAIT_IDLE;
                    rd_ff[`ST_FAULT] <= fault_ff;
                    rd_ff[`ST_EVENT] <= event_ff;
                end
                `OFF_OUTS: begin
                    rd_ff <= 32'h0000_0000;
                    rd_ff[0 +: NUM_REG] <= en_ff;
                    rd_ff[`OUTS_SEL_LSB +: NUM_REG] <= sel_ff;
                    rd_ff[`OUTS_PIN_LSB +: NUM_PIN] <= pin_level;
                    rd_ff[`OUTS_GRP_LSB +: `GRP_W] <= grp_ff;
                end
                default: rd_ff <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= `CTRL_RST;
            reg_step_ff <= 32'h0000_0000;
            reg_mode_ff <= 32'h0000_0000;
            rise_ff <= 32'h0000_0000;
            fall_ff <= 32'h0000_0000;
            pol_ff <= 32'h0000_0000;
            wait_time_ff <= 32'h0000_0000;
        end else if (wr) begin
            case (paddr)
                `OFF_CTRL: ctrl_ff <= pwdata;
                `OFF_REG_STEP: reg_step_ff <= pwdata;
                `OFF_REG_MODE: reg_mode_ff <= pwdata;
                `OFF_PIN_RISE: rise_ff <= pwdata;
                `OFF_PIN_FALL: fall_ff <= pwdata;
                `OFF_PIN_POL: pol_ff <= pwdata;
                `OFF_WAIT_TIME: wait_time_ff <= pwdata;
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Regulators
    // ----------------------------------------
    assign reg_enable = en_ff;
    assign reg_select_b = sel_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_ff <= '0;
            sel_ff <= '0;
        end else if (reset_mode) begin
            en_ff <= '0;
            sel_ff <= '0;
            en_ff[FIRST_LIN] <= keep_first;
        end else begin
            for (int i = 0; i < NUM_REG; i++) begin
                if (hit(step_cmd, max_cnt, ptr(reg_step_ff, i), def_sup)) begin
                    if (step_cmd.up) begin
                        en_ff[i] <= reg_mode_ff[i] || reg_mode_ff[`MODE_CONF_LSB + i];
                        sel_ff[i] <= 1'b0;
                    end else begin
                        en_ff[i] <= reg_mode_ff[`MODE_CONF_LSB + i];
                        sel_ff[i] <= reg_mode_ff[`MODE_CONF_LSB + i];
                    end
                end else if (enter_low_power && def_sup && ptr(reg_step_ff, i) == 4'h0) begin
                    en_ff[i] <= 1'b1;
                    sel_ff[i] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // Output pins
    // ----------------------------------------
    // Level is kept as active/inactive so polarity changes never glitch the step state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_ff <= '0;
        end else if (reset_mode) begin
            act_ff <= '0;
        end else begin
            for (int i = 0; i < NUM_PIN; i++) begin
                if (hit(step_cmd, max_cnt, ptr(rise_ff, i), 1'b0)) begin
                    act_ff[i] <= step_cmd.up;
                end
                if (hit(step_cmd, max_cnt, ptr(fall_ff, i), 1'b0)) begin
                    act_ff[i] <= !step_cmd.up;
                end
            end
        end
    end

    assign pin_level = act_ff ~^ pol_ff[NUM_PIN-1:0];

    // ----------------------------------------
    // Wait trigger and wait step
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            sync3_ff <= 1'b0;
        end else begin
            sync1_ff <= wait_trigger_input;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    wire logic trig_rise = sync2_ff && !sync3_ff;
    wire logic w1c = wr && paddr == `OFF_STATUS;

    // Software must clear the event before the next power-up, or the wait will not hold.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_ff <= 1'b0;
        end else if (trig_rise) begin
            event_ff <= 1'b1;
        end else if (w1c && pwdata[`ST_EVENT]) begin
            event_ff <= 1'b0;
        end
    end

    wire logic enter_wait = hit(step_cmd, max_cnt, wait_step, 1'b0) && step_cmd.up;
    wire logic timed_out = wst_ff == seq_step_pkg::WAIT_EVENT && ctrl_ff[`CTRL_TO_EN]
        && cnt_ff == 32'(TIMEOUT_CYCLES - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wst_ff <= seq_step_pkg::WAIT_IDLE;
        end else if (reset_mode) begin
            wst_ff <= seq_step_pkg::WAIT_IDLE;
        end else begin
            case (wst_ff)
                seq_step_pkg::WAIT_IDLE: begin
                    if (enter_wait) begin
                        wst_ff <= ctrl_ff[`CTRL_WAIT_MODE] ? seq_step_pkg::WAIT_DELAY
                            : seq_step_pkg::WAIT_EVENT;
                    end
                end
                seq_step_pkg::WAIT_EVENT: begin
                    if (event_ff || timed_out) begin
                        wst_ff <= seq_step_pkg::WAIT_IDLE;
                    end
                end
                seq_step_pkg::WAIT_DELAY: begin
                    if (cnt_ff >= wait_time_ff) begin
                        wst_ff <= seq_step_pkg::WAIT_IDLE;
                    end
                end
                default: wst_ff <= seq_step_pkg::WAIT_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 32'h0000_0000;
        end else if (wst_ff == seq_step_pkg::WAIT_IDLE) begin
            cnt_ff <= 32'h0000_0000;
        end else if (!(event_ff && wst_ff == seq_step_pkg::WAIT_EVENT)) begin
            cnt_ff <= cnt_ff + 32'h0000_0001;
        end
    end

    assign wait_hold = wst_ff != seq_step_pkg::WAIT_IDLE;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shutdown_ff <= 1'b0;
            fault_ff <= 1'b0;
        end else begin
            shutdown_ff <= timed_out;
            if (timed_out) begin
                fault_ff <= 1'b1;
            end else if (w1c && pwdata[`ST_FAULT]) begin
                fault_ff <= 1'b0;
            end
        end
    end

    assign shutdown_req = shutdown_ff;

    // ----------------------------------------
    // Group gate
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            grp_ff <= '0;
        end else if (step_cmd.valid && gate_step <= max_cnt) begin
            if (step_cmd.up && step_cmd.index > gate_step) begin
                grp_ff <= grp_ff | gate_sel;
            end else if (!step_cmd.up && step_cmd.index < gate_step) begin
                grp_ff <= grp_ff & ~gate_sel;
            end
        end
    end

    assign group_enable = grp_ff;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire logic hit0 = hit(step_cmd, max_cnt, ptr(reg_step_ff, 0), def_sup) && !reset_mode;
    logic [NUM_REG-1:0] at_zero;
    always_comb begin
        at_zero = '0;
        for (int i = 0; i < NUM_REG; i++) begin
            at_zero[i] = ptr(reg_step_ff, i) == 4'h0;
        end
    end
    // An event already pending ends the wait at once, so it is left out here.
    sequence s_wait_entered;
        !reset_mode && enter_wait && wst_ff == seq_step_pkg::WAIT_IDLE
            && !ctrl_ff[`CTRL_WAIT_MODE] && !event_ff && !trig_rise;
    endsequence
    sequence s_timeout;
        timed_out && !reset_mode;
    endsequence

    AST_REG_UP: assert property (hit0 && step_cmd.up |=>
        en_ff[0] == $past(reg_mode_ff[0] || reg_mode_ff[`MODE_CONF_LSB]) && !sel_ff[0])
        else $error("regulator up action wrong");
    AST_REG_DOWN: assert property (hit0 && !step_cmd.up |=>
        en_ff[0] == $past(reg_mode_ff[`MODE_CONF_LSB]) && sel_ff[0] == en_ff[0])
        else $error("regulator down action wrong");
    AST_STEP0: assert property (!def_sup && !reset_mode && !enter_low_power
        && step_cmd.valid && step_cmd.index == 4'h0 |=> $stable(en_ff) && $stable(sel_ff))
        else $error("step zero acted with default supply clear");
    AST_DEF_SUP: assert property (enter_low_power && def_sup && !reset_mode
        && !step_cmd.valid |=> (en_ff & $past(at_zero)) == $past(at_zero))
        else $error("default supply not enabled");
    AST_KEEP_FIRST: assert property (reset_mode |=> en_ff[FIRST_LIN] == $past(keep_first))
        else $error("first linear regulator reset handling wrong");
    AST_PIN_RESET: assert property (reset_mode |=> act_ff == '0)
        else $error("pin not inactive in reset mode");
    AST_PIN_ZERO: assert property (!reset_mode && step_cmd.valid
        && step_cmd.index == 4'h0 |=> $stable(act_ff))
        else $error("pin moved on step zero");
    AST_WAIT_HOLD: assert property (s_wait_entered |=> wait_hold [*2])
        else $error("wait step did not hold");
    AST_TIMEOUT: assert property (s_timeout |=> shutdown_req && fault_ff && !wait_hold)
        else $error("timeout did not request shutdown");
    AST_GROUP: assert property (step_cmd.valid && step_cmd.up && gate_step <= max_cnt
        && step_cmd.index > gate_step |=> (grp_ff & $past(gate_sel)) == $past(gate_sel))
        else $error("group not enabled");
endmodule

// File: sim/step_counter_model.sv
// Purpose: Stand-in for the step counter and mode logic that feed the step-action block.
// Assumes: One pclk domain; every output changes by non-blocking assignment after a rising edge.
// Notes: The bench calls these tasks hierarchically.
`timescale 1ns/1ps
module step_counter_model (
    // Clock
    input wire logic pclk,
    // Feedback from the block
    input wire logic wait_hold,
    // Drive into the block
    output seq_step_pkg::step_cmd_t step_cmd,
    output logic reset_mode,
    output logic enter_low_power,
    output logic wait_trigger_input
);
    initial begin
        step_cmd = '0;
        reset_mode = 1'b0;
        enter_low_power = 1'b0;
        wait_trigger_input = 1'b0;
    end

    // The counter never moves on while the wait step holds it.
    task automatic step(input logic up, input logic [3:0] idx);
        @(posedge pclk);
        while (wait_hold !== 1'b0) @(posedge pclk);
        step_cmd <= {1'b1, up, idx};
        @(posedge pclk);
        step_cmd <= '0;
    endtask

    task automatic pulse_mode(input logic low_power);
        @(posedge pclk);
        if (low_power) enter_low_power <= 1'b1;
        else reset_mode <= 1'b1;
        @(posedge pclk);
        enter_low_power <= 1'b0;
        reset_mode <= 1'b0;
    endtask

    // Held for several cycles so the pin synchroniser cannot miss it.
    task automatic trig();
        @(posedge pclk);
        wait_trigger_input <= 1'b1;
        repeat (4) @(posedge pclk);
        wait_trigger_input <= 1'b0;
    endtask
endmodule

// File: sim/tb.sv
// Purpose: Self-checking bench for the sequencer step-action block.
// Assumes: Timeout shortened to TO cycles; pready may come at any cycle.
// Notes: Expected outputs are worked out by hand from the step configuration.
`timescale 1ns/1ps
`include "seq_step_cfg.svh"
module tb;
    localparam int TO = 20;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, wait_hold, shutdown_req;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [6:0] reg_enable, reg_select_b;
    logic [4:0] pin_level;
    logic [7:0] group_enable;
    logic reset_mode, enter_low_power, wait_trigger_input;
    seq_step_pkg::step_cmd_t step_cmd;
    int mismatches = 0;
    int n_compared = 0;

    step_counter_model m (.pclk(pclk), .wait_hold(wait_hold), .step_cmd(step_cmd),
        .reset_mode(reset_mode), .enter_low_power(enter_low_power),
        .wait_trigger_input(wait_trigger_input));
    sequencer_step_actions #(.TIMEOUT_CYCLES(TO)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .step_cmd(step_cmd),
        .reset_mode(reset_mode), .enter_low_power(enter_low_power), .wait_hold(wait_hold),
        .shutdown_req(shutdown_req), .wait_trigger_input(wait_trigger_input),
        .reg_enable(reg_enable), .reg_select_b(reg_select_b), .pin_level(pin_level),
        .group_enable(group_enable));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic test_done();
        $display("mismatches %0d compared %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic err);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
        chk({31'h0, e}, {31'h0, err});
    endtask

    task automatic chk_outs(input logic [6:0] en, input logic [6:0] sel,
            input logic [4:0] pins, input logic [7:0] grp);
        chk({group_enable, 3'h0, pin_level, 1'h0, reg_select_b, 1'h0, reg_enable},
            {grp, 3'h0, pins, 1'h0, sel, 1'h0, en});
    endtask

    task automatic do_step(input logic up, input logic [3:0] idx, input logic [6:0] en,
            input logic [6:0] sel, input logic [4:0] pins, input logic [7:0] grp);
        m.step(up, idx);
        @(posedge pclk);
        #1;
        chk_outs(en, sel, pins, grp);
    endtask

    // Settle past the edge first, so a wait state launched at that edge is seen.
    task automatic count_hold(output int n);
        n = 0;
        #1;
        while (wait_hold === 1'b1 && n < 100) begin
            @(posedge pclk);
            #1;
            n++;
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_reset();
        chk_outs(7'h00, 7'h00, 5'h1F, 8'h00);
        rchk(`OFF_CTRL, `CTRL_RST, 1'b0);
        rchk(8'h40, 32'h0, 1'b1);
    endtask

    task automatic test_regs_pins();
        wr(`OFF_REG_STEP, 32'h0FF9_0322);
        wr(`OFF_REG_MODE, 32'h0000_0A79);
        wr(`OFF_PIN_RISE, 32'h0000_0032);
        wr(`OFF_PIN_FALL, 32'h0000_0066);
        wr(`OFF_PIN_POL, 32'h0000_0001);
        wr(`OFF_CTRL, 32'h00A5_8400);
        @(posedge pclk);
        #1;
        chk_outs(7'h00, 7'h00, 5'h1E, 8'h00);
        do_step(1'b1, 4'h0, 7'h00, 7'h00, 5'h1E, 8'h00);
        do_step(1'b1, 4'h2, 7'h03, 7'h00, 5'h1F, 8'h00);
        do_step(1'b1, 4'h3, 7'h03, 7'h00, 5'h1D, 8'h00);
        do_step(1'b1, 4'h5, 7'h03, 7'h00, 5'h1D, 8'hA5);
        do_step(1'b1, 4'h6, 7'h03, 7'h00, 5'h1E, 8'hA5);
        do_step(1'b1, 4'h9, 7'h03, 7'h00, 5'h1E, 8'hA5);
        rchk(`OFF_OUTS, 32'hA51E_0003, 1'b0);
        do_step(1'b0, 4'h6, 7'h03, 7'h00, 5'h1D, 8'hA5);
        do_step(1'b0, 4'h3, 7'h03, 7'h00, 5'h1F, 8'h00);
        do_step(1'b0, 4'h2, 7'h02, 7'h02, 5'h1E, 8'h00);
    endtask

    task automatic test_default();
        wr(`OFF_CTRL, 32'h00A5_8409);
        m.pulse_mode(1'b1);
        @(posedge pclk);
        #1;
        chk_outs(7'h0A, 7'h02, 5'h1E, 8'h00);
        do_step(1'b0, 4'h0, 7'h0A, 7'h0A, 5'h1E, 8'h00);
        do_step(1'b1, 4'h2, 7'h0B, 7'h08, 5'h1F, 8'h00);
        m.pulse_mode(1'b0);
        @(posedge pclk);
        #1;
        chk({20'h0, pin_level, reg_enable}, {20'h0, 5'h1E, 7'h08});
    endtask

    task automatic test_wait_event();
        int n;
        wr(`OFF_STATUS, 32'h0000_0006);
        wr(`OFF_CTRL, 32'h00A5_8474);
        m.step(1'b1, 4'h7);
        repeat (5) @(posedge pclk);
        #1;
        chk({31'h0, wait_hold}, 32'h1);
        m.trig();
        count_hold(n);
        chk({31'h0, wait_hold}, 32'h0);
        rchk(`OFF_STATUS, 32'h0000_0004, 1'b0);
        wr(`OFF_STATUS, 32'h0000_0004);
        rchk(`OFF_STATUS, 32'h0, 1'b0);
    endtask

    task automatic test_wait_timeout();
        int n;
        m.step(1'b1, 4'h7);
        n = 0;
        while (shutdown_req !== 1'b1 && n < 60) begin
            @(posedge pclk);
            #1;
            n++;
        end
        chk({31'h0, n >= TO - 3 && n <= TO + 3}, 32'h1);
        rchk(`OFF_STATUS, 32'h0000_0002, 1'b0);
    endtask

    task automatic test_wait_delay();
        int n;
        wr(`OFF_WAIT_TIME, 32'h0000_0006);
        wr(`OFF_CTRL, 32'h00A5_8472);
        m.step(1'b1, 4'h7);
        count_hold(n);
        chk({31'h0, n >= 5 && n <= 8}, 32'h1);
    endtask

    // ----------------------------------------
    // Clock, reset, sequence and watchdog
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        test_reset();
        test_regs_pins();
        test_default();
        test_wait_event();
        test_wait_timeout();
        test_wait_delay();
        test_done();
    end

    // A hung wait or bus transfer ends the run here instead of running forever.
    initial begin
        repeat (3000) @(posedge pclk);
        mismatches++;
        test_done();
    end
endmodule
